// >>> deser_parallel_video_output.sv
// parallel video output stage of a serial video link receiver
// Behaviour
// - each colour bus is eight bits with bit 7 most and bit 0 least significant.
// - with power_down_bar low every video output takes its sleep state.
// - blue colour pins are strap inputs at power-up; all colour pins drive video only afterwards.
// - in link mode 01 hsync and data valid pass only when at least 3 pixel clocks long.
// - in link mode 00 hsync and data valid transitions pass with no minimum length.
// - the pixel clock output strobes data on the edge picked by clock_edge_choice.
// - lock is high while the recovery loop is locked and power_down_bar is high; outputs are then live once strap capture is done.
// - lock is low when unlocked and all video outputs take their sleep state.
// - clock_edge_choice 1 strobes on the rising edge, 0 on the falling edge.
// - output_sleep_state_choice alone decides the sleep output states, the same with power_down_bar low as when unlocked.
`timescale 1ns/100ps
`default_nettype none
module deser_parallel_video_output #(
  parameter int MIN_PULSE = deser_out_pkg::FILT_MIN_PCLKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic power_down_bar,
  input wire logic pll_locked,
  input wire logic rec_pclk,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] rx_red,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] rx_green,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] rx_blue,
  input wire logic rx_hsync,
  input wire logic rx_vsync,
  input wire logic rx_dvalid,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] red_in,
  output logic [deser_out_pkg::COLOUR_W-1:0] red_out,
  output logic red_oe,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] green_in,
  output logic [deser_out_pkg::COLOUR_W-1:0] green_out,
  output logic green_oe,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] blue_in,
  output logic [deser_out_pkg::COLOUR_W-1:0] blue_out,
  output logic blue_oe,
  output logic horizontal_sync,
  output logic vertical_sync,
  output logic data_valid,
  output logic pix_clk,
  output logic ctrl_oe,
  output logic lock,
  output logic [1:0] link_mode,
  output logic output_sleep_state_choice,
  output logic clock_edge_choice,
  output logic strap_done
);
  import deser_out_pkg::*;

  localparam int CW = COLOUR_W;
  localparam int PIX_W = 3 * CW + 1;
  localparam int ASYNC_W = PIX_W + 5;
  localparam int DLY = MIN_PULSE - 1;

  // ****************
  // input synchronisers
  // ****************
  logic [ASYNC_W-1:0] async_s1_reg;
  logic [ASYNC_W-1:0] async_s2_reg;
  logic [3*CW-1:0] strap_s1_reg;
  logic [3*CW-1:0] strap_s2_reg;
  wire logic [ASYNC_W-1:0] async_raw = {power_down_bar, pll_locked, rec_pclk, rx_hsync,
                                        rx_dvalid, rx_vsync, rx_red, rx_green, rx_blue};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      async_s1_reg <= '0;
      async_s2_reg <= '0;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
    end else begin
      async_s1_reg <= async_raw;
      async_s2_reg <= async_s1_reg;
      strap_s1_reg <= {red_in, green_in, blue_in};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  wire logic pdb_s = async_s2_reg[ASYNC_W-1];
  wire logic locked_s = async_s2_reg[ASYNC_W-2];
  wire logic pclk_s = async_s2_reg[ASYNC_W-3];
  wire logic hsync_s = async_s2_reg[ASYNC_W-4];
  wire logic dvalid_s = async_s2_reg[ASYNC_W-5];
  wire logic [PIX_W-1:0] pix_s = async_s2_reg[PIX_W-1:0];
  wire logic [CW-1:0] strap_blue = strap_s2_reg[CW-1:0];

  // ****************
  // power-up strap capture
  // ****************
  boot_state_e state_reg;
  boot_state_e state_next;
  logic [STRAP_CNT_W-1:0] wait_reg;
  logic [STRAP_CNT_W-1:0] wait_next;
  logic [1:0] mode_reg;
  logic sleep_sel_reg;
  logic edge_sel_reg;
  localparam logic [STRAP_CNT_W-1:0] WAIT_LAST = STRAP_CNT_W'(STRAP_WAIT_CYC - 1);
  wire logic wait_over = (wait_reg == WAIT_LAST);
  wire logic capture = (state_reg == ST_STRAP) && wait_over;

  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    case (state_reg)
      ST_STRAP: begin
        wait_next = wait_reg + STRAP_CNT_W'(1);
        if (wait_over) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        wait_next = wait_reg;
      end
      default: begin
        state_next = ST_STRAP;
        wait_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_STRAP;
      wait_reg <= '0;
      mode_reg <= MODE_FILT_OFF;
      sleep_sel_reg <= SLEEP_FLOAT;
      edge_sel_reg <= RST_LEVEL;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      if (capture) begin
        mode_reg <= {strap_blue[STRAP_MODE_HI_BIT], strap_blue[STRAP_MODE_LO_BIT]};
        sleep_sel_reg <= strap_blue[STRAP_SLEEP_BIT];
        edge_sel_reg <= strap_blue[STRAP_EDGE_BIT];
      end
    end
  end

  wire logic booted = (state_reg == ST_RUN);
  wire logic video_on = booted && pdb_s && locked_s;
  wire logic drive_sleep = booted && (sleep_sel_reg == SLEEP_LOW);

  // ****************
  // pixel clock edges and alignment pipeline
  // ****************
  logic pclk_d_reg;
  logic [PIX_W-1:0] pipe_reg [DLY];
  wire logic rise = pclk_s && !pclk_d_reg;
  wire logic fall = !pclk_s && pclk_d_reg;
  wire logic filt_on = (mode_reg == MODE_FILT_ON);
  logic hsync_f;
  logic dvalid_f;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pclk_d_reg <= 1'b0;
      for (int i = 0; i < DLY; i++) begin
        pipe_reg[i] <= '0;
      end
    end else begin
      pclk_d_reg <= pclk_s;
      if (rise) begin
        pipe_reg[0] <= pix_s;
        for (int i = 1; i < DLY; i++) begin
          pipe_reg[i] <= pipe_reg[i-1];
        end
      end
    end
  end

  ctrl_pulse_filter #(.MIN_LEN(MIN_PULSE)) u_hsync_filt (
    .clk(clk),
    .rst_b(rst_b),
    .tick(rise),
    .filt_on(filt_on),
    .din(hsync_s),
    .dout(hsync_f)
  );

  ctrl_pulse_filter #(.MIN_LEN(MIN_PULSE)) u_dvalid_filt (
    .clk(clk),
    .rst_b(rst_b),
    .tick(rise),
    .filt_on(filt_on),
    .din(dvalid_s),
    .dout(dvalid_f)
  );

  // ****************
  // output stage
  // ****************
  logic [PIX_W-1:0] pix_out_reg;
  logic pix_clk_reg;
  logic lock_reg;
  logic hold_reg;
  wire logic [PIX_W-1:0] pix_tail = pipe_reg[DLY-1];
  wire logic [PIX_W-1:0] pix_next = !video_on ? '0 : rise ? pix_tail : pix_out_reg;
  // data moves at the non-strobe edge so it is steady at the strobe edge
  wire logic pclk_next = !video_on ? 1'b0 :
                         rise ? !edge_sel_reg :
                         fall ? edge_sel_reg : pix_clk_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pix_out_reg <= '0;
      pix_clk_reg <= 1'b0;
      lock_reg <= 1'b0;
      hold_reg <= 1'b1;
    end else begin
      pix_out_reg <= pix_next;
      pix_clk_reg <= pclk_next;
      lock_reg <= pdb_s && locked_s;
      hold_reg <= !video_on;
    end
  end

  // bit 7 of each bus is its most significant bit
  assign red_out = pix_out_reg[3*CW-1:2*CW];
  assign green_out = pix_out_reg[2*CW-1:CW];
  assign blue_out = pix_out_reg[CW-1:0];
  assign vertical_sync = pix_out_reg[PIX_W-1];
  assign horizontal_sync = hsync_f && !hold_reg;
  assign data_valid = dvalid_f && !hold_reg;
  assign pix_clk = pix_clk_reg;
  assign ctrl_oe = booted && (!hold_reg || drive_sleep);
  assign red_oe = ctrl_oe;
  assign green_oe = ctrl_oe;
  assign blue_oe = ctrl_oe;
  assign lock = lock_reg;
  assign link_mode = mode_reg;
  assign output_sleep_state_choice = sleep_sel_reg;
  assign clock_edge_choice = edge_sel_reg;
  assign strap_done = booted;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sleep_enter;
    !video_on ##1 !video_on;
  endsequence

  sequence s_live_rise;
    video_on && rise;
  endsequence

  a_sleep_outputs: assert property (s_sleep_enter |->
    (red_out == '0 && vertical_sync == 1'b0 && horizontal_sync == 1'b0 && pix_clk == 1'b0))
    else $error("video outputs live while asleep");
  a_strap_no_drive: assert property (!booted |-> !red_oe && !green_oe && !blue_oe)
    else $error("colour pins driven during strap sampling");
  a_edge_strobe: assert property (s_live_rise ##1 video_on |->
    (pix_clk == !edge_sel_reg) && (red_out == $past(pix_tail[3*CW-1:2*CW])))
    else $error("data changed at the strobe edge");
  a_lock_rise: assert property ($rose(pdb_s && locked_s) |=> lock)
    else $error("lock did not follow the recovery loop");
  a_unlock_sleep: assert property ((booted && !locked_s) |=> !lock ##1 !pix_clk)
    else $error("outputs live while unlocked");
  a_sleep_choice: assert property (s_sleep_enter ##0 booted |->
    (ctrl_oe == (sleep_sel_reg == SLEEP_LOW)))
    else $error("sleep drive does not match the sleep choice");
  a_strap_time: assert property ($rose(booted) |-> $past(wait_reg) == WAIT_LAST)
    else $error("straps captured at the wrong time");
  a_msb_order: assert property (s_live_rise |=> red_out[CW-1] == $past(pix_tail[3*CW-1]))
    else $error("colour bit order broken");
endmodule : deser_parallel_video_output
`default_nettype wire

// >>> deser_out_pkg.sv
// constants shared by the parallel video output stage
package deser_out_pkg;
  localparam int COLOUR_W = 8;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STRAP_WAIT_NS = 100;
  localparam int STRAP_WAIT_CYC = (STRAP_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRAP_CNT_W = 8;
  localparam int FILT_MIN_PCLKS = 3;
  localparam logic [1:0] MODE_FILT_OFF = 2'h0;
  localparam logic [1:0] MODE_FILT_ON = 2'h1;
  localparam int STRAP_MODE_HI_BIT = 7;
  localparam int STRAP_MODE_LO_BIT = 6;
  localparam int STRAP_SLEEP_BIT = 2;
  localparam int STRAP_EDGE_BIT = 1;
  localparam logic SLEEP_FLOAT = 1'b0;
  localparam logic SLEEP_LOW = 1'b1;
  localparam logic RST_LEVEL = 1'b0;
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN = 2'b10
  } boot_state_e;
endpackage : deser_out_pkg

// >>> ctrl_pulse_filter.sv
// minimum pulse length filter for one video control signal
`timescale 1ns/100ps
`default_nettype none
module ctrl_pulse_filter #(
  parameter int MIN_LEN = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic filt_on,
  input wire logic din,
  output logic dout
);
  logic [MIN_LEN-2:0] hist_reg;
  logic dout_reg;
  logic dout_next;
  wire logic [MIN_LEN-1:0] window = {hist_reg, din};
  wire logic all_high = &window;
  wire logic all_low = ~|window;

  // filter: change only after MIN_LEN equal samples, else hold
  // bypass: same latency, every transition forwarded
  assign dout_next = !tick ? dout_reg :
                     !filt_on ? hist_reg[MIN_LEN-2] :
                     all_high ? 1'b1 :
                     all_low ? 1'b0 : dout_reg;
  assign dout = dout_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_reg <= '0;
      dout_reg <= 1'b0;
    end else begin
      if (tick) begin
        hist_reg <= window[MIN_LEN-2:0];
      end
      dout_reg <= dout_next;
    end
  end

  // ****************
  // checks
  // ****************
  a_filter_pass: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && filt_on && (all_high || all_low)) |=> (dout == $past(din)))
    else $error("filter did not pass a long enough pulse");
  a_filter_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && filt_on && !all_high && !all_low) |=> $stable(dout))
    else $error("filter let a short pulse through");
  a_bypass_pass: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && !filt_on) |=> (dout == $past(hist_reg[MIN_LEN-2])))
    else $error("bypass did not forward the transition");
endmodule : ctrl_pulse_filter
`default_nettype wire

// >>> video_source_model.sv
// pixel source model feeding the recovered video link
`timescale 1ns/100ps
`default_nettype none
module video_source_model (
  input wire logic run,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] px_red,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] px_green,
  input wire logic [deser_out_pkg::COLOUR_W-1:0] px_blue,
  input wire logic px_hsync,
  input wire logic px_vsync,
  input wire logic px_dvalid,
  output var logic rec_pclk,
  output var logic [deser_out_pkg::COLOUR_W-1:0] rx_red,
  output var logic [deser_out_pkg::COLOUR_W-1:0] rx_green,
  output var logic [deser_out_pkg::COLOUR_W-1:0] rx_blue,
  output var logic rx_hsync,
  output var logic rx_vsync,
  output var logic rx_dvalid
);
  import deser_out_pkg::*;
  // clock stands still low between frames; data moves on the falling edge
  initial begin
    rec_pclk = 1'b0;
    rx_red = 8'h00;
    rx_green = 8'h00;
    rx_blue = 8'h00;
    rx_hsync = 1'b0;
    rx_vsync = 1'b0;
    rx_dvalid = 1'b0;
    #1.3;
    forever begin
      #16;
      if (run || rec_pclk) begin
        rec_pclk = ~rec_pclk;
        if (!rec_pclk) begin
          rx_red = px_red;
          rx_green = px_green;
          rx_blue = px_blue;
          rx_hsync = px_hsync;
          rx_vsync = px_vsync;
          rx_dvalid = px_dvalid;
        end
      end else begin
        // idle colour lines carry no stale value
        rx_red = ~rx_red;
        rx_green = ~rx_green;
        rx_blue = ~rx_blue;
      end
    end
  end
endmodule : video_source_model
`default_nettype wire

// >>> test_deser_parallel_video_output.sv
// self-checking bench for the parallel video output stage
`timescale 1ns/100ps
`default_nettype none
module test_deser_parallel_video_output;
  import deser_out_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, power_down_bar = 1'b1, pll_locked = 1'b1, run = 1'b0;
  logic px_h = 1'b0, px_v = 1'b0, px_d = 1'b0, hs_seen = 1'b0, dv_seen = 1'b0;
  logic [COLOUR_W-1:0] blue_in = 8'h00, px_r = 8'h00, px_g = 8'h00, px_b = 8'h00;
  logic [COLOUR_W-1:0] rx_red, rx_green, rx_blue, red_out, green_out, blue_out;
  logic rec_pclk, rx_hsync, rx_vsync, rx_dvalid, red_oe, green_oe, blue_oe, horizontal_sync;
  logic vertical_sync, data_valid, pix_clk, ctrl_oe, lock, output_sleep_state_choice;
  logic clock_edge_choice, strap_done;
  logic [1:0] link_mode;
  int errors = 0, tests_run = 0, cyc = 0;

  video_source_model video_source_model_i (.run, .px_red(px_r), .px_green(px_g),
    .px_blue(px_b), .px_hsync(px_h), .px_vsync(px_v), .px_dvalid(px_d), .rec_pclk,
    .rx_red, .rx_green, .rx_blue, .rx_hsync, .rx_vsync, .rx_dvalid);

  deser_parallel_video_output #(.MIN_PULSE(FILT_MIN_PCLKS)) deser_parallel_video_output_i (
    .clk, .rst_b, .power_down_bar, .pll_locked, .rec_pclk, .rx_red, .rx_green, .rx_blue,
    .rx_hsync, .rx_vsync, .rx_dvalid, .red_in(8'h00), .red_out, .red_oe, .green_in(8'h00),
    .green_out, .green_oe, .blue_in, .blue_out, .blue_oe, .horizontal_sync, .vertical_sync,
    .data_valid, .pix_clk, .ctrl_oe, .lock, .link_mode, .output_sleep_state_choice,
    .clock_edge_choice, .strap_done);

  always #2 clk = ~clk;

  // ************************************************
  // monitors, watchdog and shared tasks
  // ************************************************
  always @(negedge clk) begin
    if (horizontal_sync === 1'b1) hs_seen = 1'b1;
    if (data_valid === 1'b1) dv_seen = 1'b1;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task hold(input int n);
    repeat (n) @(negedge rec_pclk);
  endtask : hold

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task run_cfg(input logic [1:0] mode, input logic slp, input logic edg);
    int i;
    tick(1);
    rst_b <= 1'b0;
    run <= 1'b0;
    power_down_bar <= 1'b1;
    pll_locked <= 1'b1;
    blue_in <= {mode, 3'h0, slp, edg, 1'b0};
    px_v <= 1'b1;
    tick(5);
    check(red_oe, 8'h00);
    rst_b <= 1'b1;
    for (i = 0; i < 100 && strap_done !== 1'b1; i++) tick(1);
    tick(1);
    check(strap_done, 8'h01);
    check({link_mode, output_sleep_state_choice, clock_edge_choice}, {mode, slp, edg});
    px_r <= 8'hA5;
    px_g <= 8'h3C;
    px_b <= 8'h81;
    run <= 1'b1;
    hold(6);
    check(red_out, 8'hA5);
    check(green_out, 8'h3C);
    check(blue_out, 8'h81);
    check({vertical_sync, lock, red_oe, ctrl_oe}, 8'h0F);
    tick(1);
    px_r <= 8'h5A;
    for (i = 0; i < 100 && red_out === 8'hA5; i++) tick(1);
    tick(1);
    check(red_out, 8'h5A);
    check(pix_clk, !edg);
    // two-clock hsync pulse and three-clock data valid pulse
    tick(1);
    hs_seen = 1'b0;
    dv_seen = 1'b0;
    px_h <= 1'b1;
    px_d <= 1'b1;
    hold(2);
    tick(1);
    px_h <= 1'b0;
    hold(1);
    tick(1);
    px_d <= 1'b0;
    hold(8);
    check(hs_seen, mode != MODE_FILT_ON);
    check(dv_seen, 8'h01);
    tick(1);
    power_down_bar <= 1'b0;
    tick(8);
    check(red_out | green_out | blue_out, 8'h00);
    check({lock, pix_clk, horizontal_sync, data_valid, vertical_sync}, 8'h00);
    check({red_oe, green_oe, blue_oe, ctrl_oe}, {4{slp}});
    power_down_bar <= 1'b1;
    pll_locked <= 1'b0;
    tick(8);
    check(lock, 8'h00);
    check(red_out, 8'h00);
    check({pix_clk, horizontal_sync, data_valid}, 8'h00);
    check({blue_oe, ctrl_oe}, {2{slp}});
    run <= 1'b0;
    tick(20);
    $display("test done mode %h sleep %h edge %h", mode, slp, edg);
  endtask : run_cfg

  initial begin
    run_cfg(MODE_FILT_ON, SLEEP_LOW, 1'b1);
    run_cfg(MODE_FILT_OFF, SLEEP_FLOAT, 1'b0);
    end_of_test();
  end
endmodule : test_deser_parallel_video_output
`default_nettype wire
